// *** verilog/hisel_pkg.sv ***
// Purpose: Shared constants for the strap-driven host interface selector.
// Assumes: 20 MHz ref_clk; straps read as 1 when linked or placed in position 1-2.
// Notes: Pin vector indices define the layout carried by hisel_pin_if.
package hisel_pkg;
   localparam int CLK_HZ = 20_000_000;
   // Pin vector layout.
   localparam int PIN_W = 12;
   localparam int IX_SER_PAR = 0;
   localparam int IX_STYLE_A = 1;
   localparam int IX_STYLE_B = 2;
   localparam int IX_BAUD0 = 3;
   localparam int IX_ROLE0 = 6;
   localparam int IX_LINK_B = 8;
   localparam int IX_STB1 = 9;
   localparam int IX_STB2 = 10;
   localparam int IX_HOST_BUSY = 11;
   localparam logic [PIN_W-1:0] PIN_RST = 12'h000;
   // Baud rates in bit/s and their bit periods in ref_clk cycles (rounded down).
   localparam int BAUD_LO = 9600;
   localparam int BAUD_MID = 19200;
   localparam int BAUD_HI = 38400;
   localparam logic [11:0] DIV_LO = 12'(CLK_HZ / BAUD_LO);
   localparam logic [11:0] DIV_MID = 12'(CLK_HZ / BAUD_MID);
   localparam logic [11:0] DIV_HI = 12'(CLK_HZ / BAUD_HI);
   localparam logic [11:0] DIV_RST = 12'h000;
   // Baud strap codes (bit0 first link, bit1 second, bit2 third).
   localparam logic [2:0] BAUD_OPEN = 3'h0;
   localparam logic [2:0] BAUD_L1 = 3'h1;
   localparam logic [2:0] BAUD_L2 = 3'h2;
   // Spare pin role codes.
   localparam logic [1:0] ROLE_NONE = 2'h0;
   localparam logic [1:0] ROLE_RESET = 2'h1;
   localparam logic [1:0] ROLE_BUSY = 2'h2;
   // Cycles to wait after reset before straps are taken.
   localparam logic [2:0] SETTLE_CYC = 3'h4;
   typedef enum logic [2:0] {
      ST_SETTLE = 3'b000,
      ST_OPEN = 3'b001,
      ST_LOCK_SYNC = 3'b011,
      ST_LOCK_PAR = 3'b101,
      ST_ASYNC = 3'b100,
      ST_BAD = 3'b010
   } hisel_state_t;
endpackage

// *** verilog/hisel_pin_if.sv ***
// Purpose: Carries the filtered pin levels from the synchroniser to the selector.
// Assumes: One clock domain.
// Notes: Levels are stable values, already filtered.
`timescale 1ns/1ps
interface hisel_pin_if;
   logic [hisel_pkg::PIN_W-1:0] lvl;
   modport src (output lvl);
   modport dst (input lvl);
endinterface

// *** verilog/hisel_sync3.sv ***
// Purpose: Three-stage synchroniser with agreement filter for every strap and every input pin but the spare pin.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes: A level is accepted only when the second and third stages agree.
`timescale 1ns/1ps
module hisel_sync3 (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Raw pins.
   input wire logic [hisel_pkg::PIN_W-1:0] pins_raw,
   // Filtered levels.
   hisel_pin_if.src pins
);
   logic [hisel_pkg::PIN_W-1:0] s1_q, s2_q, s3_q, lvl_q;
   wire [hisel_pkg::PIN_W-1:0] agree = ~(s2_q ^ s3_q);
   wire [hisel_pkg::PIN_W-1:0] lvl_d = (agree & s3_q) | (~agree & lvl_q);

   ////////////////////////////////////////////////////////////////////////////
   // First stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         s1_q <= hisel_pkg::PIN_RST;
         s2_q <= hisel_pkg::PIN_RST;
         s3_q <= hisel_pkg::PIN_RST;
         lvl_q <= hisel_pkg::PIN_RST;
      end else begin
         s1_q <= pins_raw;
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   assign pins.lvl = lvl_q;
endmodule // hisel_sync3

// *** verilog/hisel_top.sv ***
// Purpose: Strap-driven choice of host port, parallel strobe style and spare pin role.
// Assumes: Straps are static after power-up; byte-done pulses come from ref_clk logic.
// Notes: Straps are taken once, SETTLE_CYC cycles after reset release.
`timescale 1ns/1ps
module hisel_top (
   // Clock and reset.
   input wire logic ref_clk,
   input wire logic rstn,
   // Straps (1 = linked or position 1-2).
   input wire logic serial_parallel_strap,
   input wire logic bus_style_strap_a,
   input wire logic bus_style_strap_b,
   input wire logic [2:0] baud_select_strap,
   input wire logic [1:0] spare_pin_role_strap,
   // Serial connector link pins and flow control.
   output logic async_link_pin_a,
   input wire logic async_link_pin_b,
   input wire logic host_busy_in,
   output logic module_busy_out,
   // Parallel strobe pins (pin 5 and pin 6).
   input wire logic par_strobe_1,
   input wire logic par_strobe_2,
   // Spare parallel connector pin.
   input wire logic spare_pin_i,
   output logic spare_pin_o,
   output logic spare_pin_oe,
   // Port receivers.
   input wire logic sync_byte_done,
   input wire logic par_byte_done,
   input wire logic rx_full,
   // Selection results.
   output logic sync_port_en_q,
   output logic par_port_en_q,
   output logic async_mode_q,
   output logic self_test_q,
   output logic strobe_pair_style_q,
   output logic [11:0] baud_div_q,
   output logic par_wr_q,
   output logic par_rd_q,
   output logic spare_reset_req_q,
   output logic tx_hold_q
);
   hisel_pin_if pins ();

   hisel_sync3 u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .pins_raw({host_busy_in, par_strobe_2, par_strobe_1, async_link_pin_b,
                 spare_pin_role_strap, baud_select_strap, bus_style_strap_b,
                 bus_style_strap_a, serial_parallel_strap}),
      .pins(pins)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Decode of the filtered straps.
   hisel_pkg::hisel_state_t st_q, st_d;
   logic [2:0] settle_q;
   logic [1:0] role_q;
   logic stb1_q, stb2_q;
   logic spare_s1_q, spare_s2_q, spare_s3_q, spare_q;
   wire [hisel_pkg::PIN_W-1:0] lv = pins.lvl;
   wire ser_linked = lv[hisel_pkg::IX_SER_PAR];
   wire style_pair = lv[hisel_pkg::IX_STYLE_A] & lv[hisel_pkg::IX_STYLE_B];
   wire links_joined = ~lv[hisel_pkg::IX_LINK_B]; // Pin a drives low into pin b.
   wire [2:0] baud_lv = lv[hisel_pkg::IX_BAUD0 +: 3];
   wire async_ok = ser_linked & links_joined & style_pair;
   wire capture = (st_q == hisel_pkg::ST_SETTLE) && (settle_q == hisel_pkg::SETTLE_CYC);

   // Baud divider choice; an unlisted code falls back to the lowest rate.
   function automatic logic [11:0] baud_div(input logic [2:0] code);
      case (code)
         hisel_pkg::BAUD_L1: baud_div = hisel_pkg::DIV_MID;
         hisel_pkg::BAUD_L2: baud_div = hisel_pkg::DIV_HI;
         default: baud_div = hisel_pkg::DIV_LO;
      endcase
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Port selection state machine; parallel wins a same-cycle tie.
   always_comb begin
      st_d = st_q;
      case (st_q)
         hisel_pkg::ST_SETTLE: begin
            if (capture) begin
               if (!ser_linked) st_d = hisel_pkg::ST_OPEN;
               else if (async_ok) st_d = hisel_pkg::ST_ASYNC;
               else st_d = hisel_pkg::ST_BAD;
            end
         end
         hisel_pkg::ST_OPEN: begin
            if (par_byte_done) st_d = hisel_pkg::ST_LOCK_PAR;
            else if (sync_byte_done) st_d = hisel_pkg::ST_LOCK_SYNC;
         end
         hisel_pkg::ST_LOCK_SYNC: st_d = st_q;
         hisel_pkg::ST_LOCK_PAR: st_d = st_q;
         hisel_pkg::ST_ASYNC: st_d = st_q;
         hisel_pkg::ST_BAD: st_d = st_q;
         default: st_d = hisel_pkg::ST_SETTLE;
      endcase
   end

   wire sync_en_d = (st_d == hisel_pkg::ST_OPEN) || (st_d == hisel_pkg::ST_LOCK_SYNC);
   wire par_en_d = (st_d == hisel_pkg::ST_OPEN) || (st_d == hisel_pkg::ST_LOCK_PAR);

   // State, settle counter and the straps captured at start-up.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         st_q <= hisel_pkg::ST_SETTLE;
         settle_q <= 3'h0;
         sync_port_en_q <= 1'b0;
         par_port_en_q <= 1'b0;
         async_mode_q <= 1'b0;
         self_test_q <= 1'b0;
         strobe_pair_style_q <= 1'b0;
         baud_div_q <= hisel_pkg::DIV_RST;
         role_q <= hisel_pkg::ROLE_NONE;
      end else begin
         st_q <= st_d;
         if (!capture && st_q == hisel_pkg::ST_SETTLE) settle_q <= settle_q + 3'h1;
         sync_port_en_q <= sync_en_d;
         par_port_en_q <= par_en_d;
         async_mode_q <= (st_d == hisel_pkg::ST_ASYNC);
         if (capture) begin
            strobe_pair_style_q <= style_pair;
            self_test_q <= async_ok & baud_lv[2];
            baud_div_q <= async_ok ? baud_div(baud_lv) : hisel_pkg::DIV_RST;
            role_q <= lv[hisel_pkg::IX_ROLE0 +: 2];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Parallel strobe decode; edges are taken from filtered levels only.
   wire stb1_fall = stb1_q & ~lv[hisel_pkg::IX_STB1];
   wire stb2_fall = stb2_q & ~lv[hisel_pkg::IX_STB2];
   wire wr_d = par_port_en_q & (strobe_pair_style_q ? stb1_fall
                                : stb2_fall & ~lv[hisel_pkg::IX_STB1]);
   wire rd_d = par_port_en_q & (strobe_pair_style_q ? stb2_fall
                                : stb2_fall & lv[hisel_pkg::IX_STB1]);
   wire busy_d = rx_full | ~(sync_en_d | par_en_d | (st_d == hisel_pkg::ST_ASYNC));
   // The spare pin comes from the connector, so it gets its own three-stage filter.
   // A reset request is only raised once two stages agree, which rejects glitches.
   wire spare_d = (spare_s2_q == spare_s3_q) ? spare_s3_q : spare_q;

   // Strobes, busy and spare pin outputs.
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         stb1_q <= 1'b1;
         stb2_q <= 1'b1;
         par_wr_q <= 1'b0;
         par_rd_q <= 1'b0;
         module_busy_out <= 1'b1;
         tx_hold_q <= 1'b0;
         async_link_pin_a <= 1'b0;
         spare_pin_o <= 1'b0;
         spare_pin_oe <= 1'b0;
         spare_s1_q <= 1'b1;
         spare_s2_q <= 1'b1;
         spare_s3_q <= 1'b1;
         spare_q <= 1'b1;
         spare_reset_req_q <= 1'b0;
      end else begin
         stb1_q <= lv[hisel_pkg::IX_STB1];
         stb2_q <= lv[hisel_pkg::IX_STB2];
         par_wr_q <= wr_d;
         par_rd_q <= rd_d;
         module_busy_out <= busy_d;
         tx_hold_q <= lv[hisel_pkg::IX_HOST_BUSY];
         spare_pin_o <= busy_d;
         spare_pin_oe <= (role_q == hisel_pkg::ROLE_BUSY);
         spare_s1_q <= spare_pin_i;
         spare_s2_q <= spare_s1_q;
         spare_s3_q <= spare_s2_q;
         spare_q <= spare_d;
         spare_reset_req_q <= (role_q == hisel_pkg::ROLE_RESET) & ~spare_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks and coverage.
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!rstn);

   a_open_both_en: assert property ((st_q == hisel_pkg::ST_OPEN) && !sync_byte_done
      && !par_byte_done |=> sync_port_en_q && par_port_en_q) else $error("open not both");
   a_first_byte_lock: assert property ((st_q == hisel_pkg::ST_OPEN) && sync_byte_done
      && !par_byte_done |=> (sync_port_en_q && !par_port_en_q) [*3]) else $error("no sync lock");
   a_par_lock_wins: assert property ((st_q == hisel_pkg::ST_OPEN) && par_byte_done
      |=> par_port_en_q && !sync_port_en_q) else $error("no parallel lock");
   a_async_entry: assert property (capture && !async_ok |=> !async_mode_q [*4])
      else $error("async without straps");
   a_pair_write: assert property (par_port_en_q && strobe_pair_style_q && stb1_fall
      |=> par_wr_q && !par_rd_q) else $error("pair write missed");
   a_dir_en_read: assert property (par_port_en_q && !strobe_pair_style_q && stb2_fall
      && lv[hisel_pkg::IX_STB1] |=> par_rd_q && !par_wr_q) else $error("read missed");
   a_dir_en_write: assert property (par_port_en_q && !strobe_pair_style_q && stb2_fall
      && !lv[hisel_pkg::IX_STB1] |=> par_wr_q && !par_rd_q) else $error("write missed");
   a_baud_mid_div: assert property (capture && async_ok && baud_lv == hisel_pkg::BAUD_L1
      |=> baud_div_q == hisel_pkg::DIV_MID) else $error("baud 19200 wrong");
   a_self_test_force: assert property (capture && async_ok && baud_lv[2]
      |=> self_test_q && async_mode_q) else $error("self test missed");
   a_spare_busy_drv: assert property (role_q == hisel_pkg::ROLE_BUSY
      |=> spare_pin_oe) else $error("spare busy not driven");
   a_spare_reset_req: assert property (role_q == hisel_pkg::ROLE_RESET && !spare_q
      |=> spare_reset_req_q) else $error("spare reset not raised");
   a_busy_follow: assert property (rx_full |=> module_busy_out)
      else $error("busy not raised");
   a_host_hold: assert property (lv[hisel_pkg::IX_HOST_BUSY] |=> tx_hold_q)
      else $error("host busy not held");

   // Coverage of the lock outcomes, the fast async rate, strobe pair writes and self test.

   c_lock_sync: cover property ((st_q == hisel_pkg::ST_OPEN) ##1 (st_q == hisel_pkg::ST_LOCK_SYNC));
   c_lock_par: cover property ((st_q == hisel_pkg::ST_OPEN) ##1 (st_q == hisel_pkg::ST_LOCK_PAR));
   c_async: cover property (async_mode_q && baud_div_q == hisel_pkg::DIV_HI);
   c_wr_pair: cover property (par_wr_q && strobe_pair_style_q);
   c_self_test: cover property (self_test_q && async_mode_q);
endmodule // hisel_top

// *** verif/hisel_host_mdl.sv ***
// Purpose: Host model that drives the parallel strobe pins and the host busy line.
// Assumes: Strobe pins idle high through the control line pull-ups.
// Notes: Every level is changed at a falling edge and held long past the input filter.
`timescale 1ns/1ps
module hisel_host_mdl (
   // Clock.
   input wire logic ref_clk,
   // Host side pins.
   output logic par_strobe_1,
   output logic par_strobe_2,
   output logic host_busy_in
);
   // Idle levels match the pull-ups, so an undriven strobe never fires.
   initial begin
      par_strobe_1 = 1'b1;
      par_strobe_2 = 1'b1;
      host_busy_in = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // One low strobe on pin 5 (write) or pin 6 (read), both released after.
   task automatic pair_cycle(input logic rd);
      @(negedge ref_clk);
      if (rd) par_strobe_2 = 1'b0;
      else par_strobe_1 = 1'b0;
      repeat (8) @(negedge ref_clk);
      par_strobe_1 = 1'b1;
      par_strobe_2 = 1'b1;
      repeat (8) @(negedge ref_clk);
   endtask
   // Direction settles on pin 5 well before the enable falls on pin 6.
   task automatic dir_en_cycle(input logic rd);
      @(negedge ref_clk);
      par_strobe_1 = rd;
      repeat (6) @(negedge ref_clk);
      par_strobe_2 = 1'b0;
      repeat (8) @(negedge ref_clk);
      par_strobe_2 = 1'b1;
      repeat (6) @(negedge ref_clk);
      par_strobe_1 = 1'b1;
   endtask
   // The host holds off module transmissions while it is busy.
   task automatic set_busy(input logic b);
      @(negedge ref_clk);
      host_busy_in = b;
   endtask
endmodule // hisel_host_mdl

// *** verif/host_interface_strap_select_tb_top.sv ***
// Purpose: Self-checking bench for the strap-driven host interface selector.
// Assumes: Straps change only while reset is held; inputs move at falling edges.
// Notes: Write and read pulses are counted, so stray pulses are caught too.
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_compared++; if ((a) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, a); end end
module host_interface_strap_select_tb_top;
   logic ref_clk = 1'b0;
   logic rstn;
   logic sp, sa, sb, join_q, rx_full, spare_i;
   logic sdone, pdone;
   logic [2:0] baud;
   logic [1:0] role;
   logic link_a, link_b, hbusy, mbusy, stb1, stb2, sp_o, sp_oe, rst_req, hold;
   logic sync_en, par_en, async_m, self_t, pair_st, wr, rd;
   logic [11:0] div;
   logic [2:0] codes [4] = '{3'h0, 3'h1, 3'h2, 3'h5};
   logic [11:0] divs [3] = '{hisel_pkg::DIV_LO, hisel_pkg::DIV_MID, hisel_pkg::DIV_HI};
   int n_mismatch = 0, n_compared = 0, n_wr = 0, n_rd = 0, cyc = 0;
   always #25 ref_clk = ~ref_clk;
   // An open link pin is pulled high; a joined one follows the driven side.
   assign link_b = join_q ? link_a : 1'b1;
   hisel_host_mdl host (.ref_clk(ref_clk), .par_strobe_1(stb1), .par_strobe_2(stb2),
      .host_busy_in(hbusy));
   hisel_top uut (.ref_clk(ref_clk), .rstn(rstn), .serial_parallel_strap(sp),
      .bus_style_strap_a(sa), .bus_style_strap_b(sb), .baud_select_strap(baud),
      .spare_pin_role_strap(role), .async_link_pin_a(link_a), .async_link_pin_b(link_b),
      .host_busy_in(hbusy), .module_busy_out(mbusy), .par_strobe_1(stb1),
      .par_strobe_2(stb2), .spare_pin_i(spare_i), .spare_pin_o(sp_o), .spare_pin_oe(sp_oe),
      .sync_byte_done(sdone), .par_byte_done(pdone), .rx_full(rx_full),
      .sync_port_en_q(sync_en), .par_port_en_q(par_en), .async_mode_q(async_m),
      .self_test_q(self_t), .strobe_pair_style_q(pair_st), .baud_div_q(div),
      .par_wr_q(wr), .par_rd_q(rd), .spare_reset_req_q(rst_req), .tx_hold_q(hold));
   ////////////////////////////////////////////////////////////////////////////
   // Pulses are sampled mid-cycle; the cycle ceiling cuts a hang short.
   always @(negedge ref_clk) begin
      cyc++;
      if (wr === 1'b1) n_wr++;
      if (rd === 1'b1) n_rd++;
      if (cyc == 5000) begin
         n_mismatch++;
         test_done();
      end
   end
   task test_done;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   // Straps are set under reset, so they are stable long before capture.
   task cfg(input logic s, a, b, j, input logic [2:0] bd, input logic [1:0] r);
      @(negedge ref_clk);
      rstn = 1'b0;
      {sp, sa, sb, join_q, baud, role, rx_full} = {s, a, b, j, bd, r, 1'b0};
      repeat (6) @(negedge ref_clk);
      rstn = 1'b1;
      repeat (12) @(negedge ref_clk);
      n_wr = 0;
      n_rd = 0;
   endtask
   task pulse(input logic s, p);
      @(negedge ref_clk);
      {sdone, pdone} = {s, p};
      @(negedge ref_clk);
      {sdone, pdone} = 2'h0;
      repeat (3) @(negedge ref_clk);
   endtask
   task chk_en(input logic se, pe, am);
      `CHK("sync_en", se, sync_en)
      `CHK("par_en", pe, par_en)
      `CHK("async", am, async_m)
   endtask
   ////////////////////////////////////////////////////////////////////////////
   // Main sequence of tests.
   initial begin
      // Reset low, straps open, link joined, spare pin and strobes idle.
      {rstn, sp, sa, sb, join_q, rx_full, spare_i, sdone, pdone} = 9'h014;
      baud = 3'h0;
      role = 2'h0;
      cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h0);
      chk_en(1'b1, 1'b1, 1'b0);
      `CHK("busy", 1'b0, mbusy)
      `CHK("pair", 1'b0, pair_st)
      pulse(1'b1, 1'b0);
      chk_en(1'b1, 1'b0, 1'b0);
      host.dir_en_cycle(1'b0);
      pulse(1'b0, 1'b1);
      `CHK("wr", 0, n_wr)
      `CHK("par_en", 1'b0, par_en)
      $display("test sync_lock done");
      cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h0);
      pulse(1'b0, 1'b1);
      chk_en(1'b0, 1'b1, 1'b0);
      host.dir_en_cycle(1'b0);
      host.dir_en_cycle(1'b1);
      `CHK("wr", 1, n_wr)
      `CHK("rd", 1, n_rd)
      $display("test dir_enable done");
      cfg(1'b0, 1'b1, 1'b1, 1'b1, 3'h0, 2'h0);
      `CHK("pair", 1'b1, pair_st)
      pulse(1'b1, 1'b1);
      chk_en(1'b0, 1'b1, 1'b0);
      host.pair_cycle(1'b0);
      host.pair_cycle(1'b1);
      host.pair_cycle(1'b1);
      `CHK("wr", 1, n_wr)
      `CHK("rd", 2, n_rd)
      $display("test strobe_pair done");
      for (int i = 0; i < 4; i++) begin
         cfg(1'b1, 1'b1, 1'b1, 1'b1, codes[i], 2'h0);
         chk_en(1'b0, 1'b0, 1'b1);
         if (i < 3) `CHK("div", divs[i], div)
         `CHK("self", 1'(i == 3), self_t)
      end
      cfg(1'b1, 1'b1, 1'b1, 1'b0, 3'h0, 2'h0);
      chk_en(1'b0, 1'b0, 1'b0);
      `CHK("busy", 1'b1, mbusy)
      cfg(1'b1, 1'b1, 1'b0, 1'b1, 3'h0, 2'h0);
      chk_en(1'b0, 1'b0, 1'b0);
      $display("test async done");
      cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h2);
      `CHK("oe", 1'b1, sp_oe)
      rx_full = 1'b1;
      repeat (3) @(negedge ref_clk);
      `CHK("busy", 1'b1, mbusy)
      `CHK("spare_o", 1'b1, sp_o)
      rx_full = 1'b0;
      repeat (3) @(negedge ref_clk);
      `CHK("spare_o", 1'b0, sp_o)
      host.set_busy(1'b1);
      repeat (8) @(negedge ref_clk);
      `CHK("hold", 1'b1, hold)
      host.set_busy(1'b0);
      repeat (8) @(negedge ref_clk);
      `CHK("hold", 1'b0, hold)
      cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h1);
      `CHK("oe", 1'b0, sp_oe)
      spare_i = 1'b0;
      repeat (8) @(negedge ref_clk);
      `CHK("rst_req", 1'b1, rst_req)
      cfg(1'b0, 1'b0, 1'b0, 1'b1, 3'h0, 2'h0);
      `CHK("rst_req", 1'b0, rst_req)
      `CHK("oe", 1'b0, sp_oe)
      spare_i = 1'b1;
      $display("test spare_busy done");
      test_done();
   end
endmodule // host_interface_strap_select_tb_top
